/* File: core/iss_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_exec #(
  parameter int PAUSE_LIMIT = iss_pkg::PAUSE_CYCLES,
  parameter int RTC_LIMIT = iss_pkg::RTC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [5:0] opcode,
  input wire logic [3:0] variant,
  input wire logic [16:0] operand,
  input wire logic [1:0] bSel,
  input wire logic [11:0] xMask,
  input wire logic [2:0] chSel,
  input wire logic [14:0] pCur,
  input wire logic [14:0] blkCount,
  input wire logic [7:0] chBusy,
  input wire logic [11:0] busyLines,
  input wire logic [11:0] statusLines,
  input wire logic [11:0] intLines,
  input wire logic chWide,
  input wire logic [23:0] inWord,
  input wire logic inValid,
  input wire logic memAck,
  input wire logic [23:0] memRdata,
  output logic done,
  output logic [14:0] pNext,
  output logic [23:0] regA,
  output logic [23:0] regQ,
  output logic [44:0] indexRegs,
  output logic [11:0] intMask,
  output logic relocOperand,
  output logic destructArmed,
  output logic memReq,
  output logic memWe,
  output logic [14:0] memAddr,
  output logic [23:0] memWdata,
  output logic [11:0] funcCode,
  output logic funcEnable,
  output logic [5:0] charOut,
  output logic charStrobe,
  output logic inReady,
  output logic [23:0] rtcCount
);
  import iss_pkg::*;

  typedef struct packed {
    iss_state_t st;
    logic [23:0] a;
    logic [23:0] q;
    logic [2:0][14:0] idx;
    logic [11:0] mask;
    logic reloc;
    logic arm;
    logic done;
    logic [14:0] pNext;
    logic memReq;
    logic memWe;
    logic [14:0] memAddr;
    logic [23:0] memWdata;
    logic [11:0] func;
    logic funcEn;
    logic [5:0] chOut;
    logic chStb;
    logic inRdy;
    logic [14:0] cnt;
    logic [5:0] scaleCnt;
    logic [5:0] opc;
    logic [3:0] vr;
    logic [16:0] opnd;
    logic [1:0] b;
    logic [11:0] x;
    logic [2:0] ch;
    logic [14:0] p;
    logic [14:0] srchIdx;
  } iss_exec_t;

  iss_exec_t s_q;
  iss_exec_t s_d;
  iss_sub_if sub();

  function automatic logic [23:0] sext15(input logic [14:0] v);
    sext15 = {{9{v[14]}}, v};
  endfunction

  function automatic logic ge24(input logic [23:0] l, input logic [23:0] r);
    ge24 = $signed(l) >= $signed(r);
  endfunction

  function automatic logic [14:0] get_idx(input logic [2:0][14:0] arr, input logic [1:0] sel);
    get_idx = (sel == 2'h0) ? RST_INDEX : arr[sel - 2'h1];
  endfunction

  function automatic logic [5:0] char_of(input logic [23:0] w, input logic [1:0] pos);
    char_of = 6'(w >> (5'd18 - 5'(pos) * 5'd6));
  endfunction

  function automatic iss_exec_t fin(input iss_exec_t v, input logic [1:0] off);
    iss_exec_t r;
    r = v;
    r.pNext = v.p + 15'(off);
    r.done = 1'b1;
    r.st = ST_IDLE;
    return r;
  endfunction

  function automatic iss_exec_t rd(input iss_exec_t v, input logic [14:0] addr, input iss_state_t nx);
    iss_exec_t r;
    r = v;
    r.memAddr = addr;
    r.memReq = 1'b1;
    r.memWe = 1'b0;
    r.st = nx;
    return r;
  endfunction

  logic [14:0] yv;
  logic [14:0] ixv;
  logic [23:0] kSum;
  logic [14:0] decIdx;
  logic [23:0] qm;
  logic [23:0] residue;

  assign sub.shDouble = (s_q.opc == OPC_SHIFT_DBL);
  assign sub.shData = sub.shDouble ? {s_q.a, s_q.q} :
                      {24'h000000, (s_q.vr == VAR_SHQ) ? s_q.q : s_q.a};
  assign sub.shCount = kSum;
  assign sub.pauseRun = (s_q.st == ST_PAUSE);
  assign sub.rtcHold = (s_q.st == ST_PAUSE) && (s_q.vr == VAR_PRP);

  iss_shifter u_shift (
    .sub(sub.shifter)
  );

  iss_pause_timer #(
    .PAUSE_LIMIT(PAUSE_LIMIT),
    .RTC_LIMIT(RTC_LIMIT)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sub(sub.timer)
  );

  always_comb begin
    yv = s_q.opnd[14:0];
    ixv = get_idx(s_q.idx, s_q.b);
    kSum = sext15(yv) + sext15(ixv);
    decIdx = s_q.srchIdx - {13'h0000, s_q.b};
    qm = s_q.q & memRdata;
    residue = sext15(yv) - {18'h00000, s_q.scaleCnt};
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.funcEn = 1'b0;
    s_d.chStb = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          s_d.opc = opcode;
          s_d.vr = variant;
          s_d.opnd = operand;
          s_d.b = bSel;
          s_d.x = xMask;
          s_d.ch = chSel;
          s_d.p = pCur;
          s_d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (s_q.opc)
          OPC_IDX_STEP: begin
            if (ixv == yv) begin
              if (s_q.b != 2'h0) begin
                s_d.idx[s_q.b - 2'h1] = RST_INDEX;
              end
              s_d = fin(s_d, OFF_SKIP);
            end else begin
              if (s_q.b != 2'h0) begin
                s_d.idx[s_q.b - 2'h1] = (s_q.vr == VAR_DEC) ? ixv - 15'h0001 :
                                        ixv + 15'h0001;
              end
              s_d = fin(s_d, OFF_NEXT);
            end
          end
          OPC_EQ_SKIP: begin
            if (s_q.vr == VAR_Q) begin
              s_d = fin(s_d, (yv == s_q.q[14:0]) ? OFF_SKIP : OFF_NEXT);
            end else if (s_q.vr == VAR_QS) begin
              s_d = fin(s_d, (sext15(yv) == s_q.q) ? OFF_SKIP : OFF_NEXT);
            end else begin
              s_d = fin(s_d, (yv == ixv) ? OFF_SKIP : OFF_NEXT);
            end
          end
          OPC_GE_SKIP: begin
            if (s_q.vr == VAR_Q) begin
              s_d = fin(s_d, ge24(s_q.q, {9'h000, yv}) ? OFF_SKIP : OFF_NEXT);
            end else if (s_q.vr == VAR_QS) begin
              s_d = fin(s_d, ge24(s_q.q, sext15(yv)) ? OFF_SKIP : OFF_NEXT);
            end else begin
              s_d = fin(s_d, ge24(sext15(ixv), sext15(yv)) ? OFF_SKIP : OFF_NEXT);
            end
          end
          OPC_CHAR_A, OPC_CHAR_Q: begin
            s_d = rd(s_d, s_q.opnd[16:2], ST_MEMRD);
          end
          OPC_LOAD_A: begin
            s_d = rd(s_d, yv, ST_MEMRD);
          end
          OPC_MASK_EQ: begin
            s_d.srchIdx = s_q.idx[0];
            s_d.st = ST_SEARCH;
          end
          OPC_MASK_GE: begin
            s_d.srchIdx = s_q.idx[1];
            s_d.st = ST_SEARCH;
          end
          OPC_SHIFT: begin
            if (s_q.vr == VAR_SHQ) begin
              s_d.q = sub.shResult[23:0];
            end else begin
              s_d.a = sub.shResult[23:0];
            end
            s_d = fin(s_d, OFF_NEXT);
          end
          OPC_SHIFT_DBL: begin
            if (s_q.vr == VAR_SCALE) begin
              s_d.scaleCnt = 6'h00;
              s_d.st = ST_SCALE;
            end else begin
              {s_d.a, s_d.q} = sub.shResult;
              s_d = fin(s_d, OFF_NEXT);
            end
          end
          OPC_RELOC: begin
            if (s_q.vr == VAR_ROS) begin
              s_d.reloc = 1'b1;
            end else begin
              s_d.reloc = 1'b0;
            end
            s_d = fin(s_d, OFF_NEXT);
          end
          OPC_CHAR_OUT: begin
            s_d.chOut = s_q.a[5:0];
            s_d.chStb = 1'b1;
            s_d = fin(s_d, OFF_NEXT);
          end
          OPC_WORD_IN: begin
            s_d.memAddr = yv;
            s_d.cnt = blkCount;
            if (blkCount == 15'h0000) begin
              s_d = fin(s_d, OFF_NEXT);
            end else begin
              s_d.inRdy = 1'b1;
              s_d.st = ST_INBLK;
            end
          end
          OPC_MISC: begin
            case (s_q.vr)
              VAR_INS: begin
                s_d = fin(s_d, ((statusLines & s_q.x) != 12'h000) ? OFF_NEXT : OFF_SKIP);
              end
              VAR_INTERRUPT_CONDITION_SENSE: begin
                s_d = fin(s_d, ((intLines & s_q.mask) != 12'h000) ? OFF_NEXT : OFF_SKIP);
              end
              VAR_MASK_SELECTIVE_CLEAR: begin
                s_d.mask = s_q.mask & ~s_q.x;
                s_d = fin(s_d, OFF_NEXT);
              end
              VAR_SSIM: begin
                s_d.mask = s_q.mask | s_q.x;
                s_d = fin(s_d, OFF_NEXT);
              end
              VAR_BUSY_LINE_PAUSE, VAR_PRP: begin
                s_d.st = ST_PAUSE;
              end
              VAR_SEL: begin
                if (chBusy[s_q.ch]) begin
                  s_d = fin(s_d, OFF_NEXT);
                end else begin
                  s_d.func = s_q.x;
                  s_d.funcEn = 1'b1;
                  s_d = fin(s_d, OFF_SKIP);
                end
              end
              VAR_SDL: begin
                s_d.arm = 1'b1;
                s_d = fin(s_d, OFF_NEXT);
              end
              default: begin
                s_d = fin(s_d, OFF_NEXT);
              end
            endcase
          end
          default: begin
            s_d = fin(s_d, OFF_NEXT);
          end
        endcase
      end
      ST_MEMRD: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          if (s_q.opc == OPC_CHAR_A) begin
            s_d.a[5:0] = char_of(memRdata, s_q.opnd[1:0]);
            s_d = fin(s_d, OFF_NEXT);
          end else if (s_q.opc == OPC_CHAR_Q) begin
            s_d.q[5:0] = char_of(memRdata, s_q.opnd[1:0]);
            s_d = fin(s_d, OFF_NEXT);
          end else if (s_q.arm) begin
            s_d.a = memRdata;
            s_d.arm = 1'b0;
            s_d.memReq = 1'b1;
            s_d.memWe = 1'b1;
            s_d.memWdata = DESTRUCT_FILL;
            s_d.st = ST_DESTR;
          end else begin
            s_d.a = memRdata;
            s_d = fin(s_d, OFF_NEXT);
          end
        end
      end
      ST_DESTR: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.memWe = 1'b0;
          s_d = fin(s_d, OFF_NEXT);
        end
      end
      ST_SEARCH: begin
        s_d.srchIdx = decIdx;
        s_d.idx[(s_q.opc == OPC_MASK_EQ) ? 0 : 1] = decIdx;
        if (decIdx[14]) begin
          s_d = fin(s_d, OFF_NEXT);
        end else begin
          s_d = rd(s_d, yv + decIdx, ST_SRCHRD);
        end
      end
      ST_SRCHRD: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          if (s_q.opc == OPC_MASK_EQ ? (s_q.a == qm) : ge24(s_q.a, qm)) begin
            s_d = fin(s_d, OFF_SKIP);
          end else begin
            s_d.st = ST_SEARCH;
          end
        end
      end
      ST_SCALE: begin
        if ((s_q.a[23] != s_q.a[22]) || (s_q.scaleCnt == SCALE_MAX)) begin
          if (s_q.b != 2'h0) begin
            s_d.idx[s_q.b - 2'h1] = residue[14:0];
          end
          s_d = fin(s_d, OFF_NEXT);
        end else begin
          {s_d.a, s_d.q} = {s_q.a[22:0], s_q.q, s_q.a[23]};
          s_d.scaleCnt = s_q.scaleCnt + 6'h01;
        end
      end
      ST_PAUSE: begin
        if ((busyLines & s_q.x) == 12'h000) begin
          s_d = fin(s_d, OFF_SKIP);
        end else if (sub.pauseExpired) begin
          s_d = fin(s_d, OFF_NEXT);
        end
      end
      ST_INBLK: begin
        if (inValid) begin
          s_d.inRdy = 1'b0;
          s_d.memWdata = chWide ? inWord : {12'h000, inWord[11:0]};
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.st = ST_INWR;
        end
      end
      ST_INWR: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.memWe = 1'b0;
          s_d.memAddr = s_q.memAddr + 15'h0001;
          s_d.cnt = s_q.cnt - 15'h0001;
          if (s_q.cnt == 15'h0001) begin
            s_d = fin(s_d, OFF_NEXT);
          end else begin
            s_d.inRdy = 1'b1;
            s_d.st = ST_INBLK;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.a <= RST_WORD;
      s_q.q <= RST_WORD;
      s_q.idx <= {RST_INDEX, RST_INDEX, RST_INDEX};
      s_q.mask <= RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign pNext = s_q.pNext;
  assign regA = s_q.a;
  assign regQ = s_q.q;
  assign indexRegs = s_q.idx;
  assign intMask = s_q.mask;
  assign relocOperand = s_q.reloc;
  assign destructArmed = s_q.arm;
  assign memReq = s_q.memReq;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign funcCode = s_q.func;
  assign funcEnable = s_q.funcEn;
  assign charOut = s_q.chOut;
  assign charStrobe = s_q.chStb;
  assign inReady = s_q.inRdy;
  assign rtcCount = sub.rtcValue;
endmodule
`default_nettype wire

/* File: core/iss_pkg.sv */
package iss_pkg;

  localparam int CLK_HZ = 25000000;
  localparam int PAUSE_MS = 40;
  localparam int RTC_STEP_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int PAUSE_CYCLES = PAUSE_MS * MS_CYCLES;
  localparam int RTC_CYCLES = RTC_STEP_MS * MS_CYCLES;
  localparam logic [5:0] SCALE_MAX = 6'h2f;

  localparam logic [5:0] OPC_IDX_STEP = 6'h08;
  localparam logic [5:0] OPC_EQ_SKIP = 6'h04;
  localparam logic [5:0] OPC_GE_SKIP = 6'h05;
  localparam logic [5:0] OPC_MASK_EQ = 6'h06;
  localparam logic [5:0] OPC_MASK_GE = 6'h07;
  localparam logic [5:0] OPC_SHIFT = 6'h0a;
  localparam logic [5:0] OPC_SHIFT_DBL = 6'h0b;
  localparam logic [5:0] OPC_LOAD_A = 6'h10;
  localparam logic [5:0] OPC_CHAR_A = 6'h12;
  localparam logic [5:0] OPC_CHAR_Q = 6'h13;
  localparam logic [5:0] OPC_RELOC = 6'h2d;
  localparam logic [5:0] OPC_WORD_IN = 6'h3c;
  localparam logic [5:0] OPC_CHAR_OUT = 6'h3d;
  localparam logic [5:0] OPC_MISC = 6'h3f;

  localparam logic [3:0] VAR_PLAIN = 4'h0;
  localparam logic [3:0] VAR_DEC = 4'h1;
  localparam logic [3:0] VAR_Q = 4'h2;
  localparam logic [3:0] VAR_QS = 4'h3;
  localparam logic [3:0] VAR_SHQ = 4'h4;
  localparam logic [3:0] VAR_SCALE = 4'h5;
  localparam logic [3:0] VAR_RIS = 4'h6;
  localparam logic [3:0] VAR_ROS = 4'h7;
  localparam logic [3:0] VAR_INS = 4'h8;
  localparam logic [3:0] VAR_INTERRUPT_CONDITION_SENSE = 4'h9;
  localparam logic [3:0] VAR_MASK_SELECTIVE_CLEAR = 4'ha;
  localparam logic [3:0] VAR_SSIM = 4'hb;
  localparam logic [3:0] VAR_BUSY_LINE_PAUSE = 4'hc;
  localparam logic [3:0] VAR_PRP = 4'hd;
  localparam logic [3:0] VAR_SEL = 4'he;
  localparam logic [3:0] VAR_SDL = 4'hf;

  localparam logic [1:0] OFF_HOLD = 2'h0;
  localparam logic [1:0] OFF_NEXT = 2'h1;
  localparam logic [1:0] OFF_SKIP = 2'h2;

  localparam logic [23:0] DESTRUCT_FILL = 24'h1fffff;
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [14:0] RST_INDEX = 15'h0000;
  localparam logic [11:0] RST_MASK = 12'h000;
  localparam logic [23:0] RST_RTC = 24'h000000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_EXEC, ST_MEMRD, ST_DESTR, ST_SEARCH, ST_SRCHRD, ST_SCALE,
    ST_PAUSE, ST_INBLK, ST_INWR
  } iss_state_t;

endpackage

/* File: core/iss_sub_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface iss_sub_if;
  logic [47:0] shData;
  logic shDouble;
  logic [23:0] shCount;
  logic [47:0] shResult;
  logic pauseRun;
  logic rtcHold;
  logic pauseExpired;
  logic [23:0] rtcValue;

  modport exec (output shData, shDouble, shCount, pauseRun, rtcHold,
                input shResult, pauseExpired, rtcValue);
  modport shifter (input shData, shDouble, shCount, output shResult);
  modport timer (input pauseRun, rtcHold, output pauseExpired, rtcValue);
endinterface
`default_nettype wire

/* File: core/iss_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_shifter (
  iss_sub_if.shifter sub
);
  import iss_pkg::*;

  logic [5:0] mag;
  logic [5:0] rot;
  logic [95:0] dbl2;
  logic [47:0] sgl2;

  always_comb begin
    mag = sub.shCount[23] ? ~sub.shCount[5:0] : sub.shCount[5:0];
    rot = sub.shDouble ? 6'(mag % 6'd48) : 6'(mag % 6'd24);
    dbl2 = {sub.shData, sub.shData} << rot;
    sgl2 = {sub.shData[23:0], sub.shData[23:0]} << rot;
    if (sub.shCount[23]) begin
      if (sub.shDouble) begin
        sub.shResult = sub.shData >> mag;
      end else begin
        sub.shResult = {24'h000000, sub.shData[23:0] >> mag};
      end
    end else if (sub.shDouble) begin
      sub.shResult = dbl2[95:48];
    end else begin
      sub.shResult = {24'h000000, sgl2[47:24]};
    end
  end
endmodule
`default_nettype wire

/* File: core/iss_pause_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_pause_timer #(
  parameter int PAUSE_LIMIT = iss_pkg::PAUSE_CYCLES,
  parameter int RTC_LIMIT = iss_pkg::RTC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  iss_sub_if.timer sub
);
  import iss_pkg::*;

  localparam int PW = $clog2(PAUSE_LIMIT + 1);
  localparam int RW = $clog2(RTC_LIMIT + 1);

  typedef struct packed {
    logic [PW-1:0] pauseCnt;
    logic expired;
    logic [RW-1:0] msCnt;
    logic [23:0] rtc;
  } iss_tmr_t;

  iss_tmr_t s_q;
  iss_tmr_t s_d;

  assign sub.pauseExpired = s_q.expired;
  assign sub.rtcValue = s_q.rtc;

  always_comb begin
    s_d = s_q;
    if (!sub.pauseRun) begin
      s_d.pauseCnt = '0;
      s_d.expired = 1'b0;
    end else if (s_q.pauseCnt == PW'(PAUSE_LIMIT - 1)) begin
      s_d.expired = 1'b1;
    end else begin
      s_d.pauseCnt = s_q.pauseCnt + PW'(1);
    end
    if (s_q.msCnt == RW'(RTC_LIMIT - 1)) begin
      s_d.msCnt = '0;
      if (!sub.rtcHold) begin
        s_d.rtc = s_q.rtc + 24'h000001;
      end
    end else begin
      s_d.msCnt = s_q.msCnt + RW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{pauseCnt: '0, expired: 1'b0, msCnt: '0, rtc: RST_RTC};
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: bench/iss_exec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_exec_asserts import iss_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] opcode,
  input wire logic [3:0] variant,
  input wire logic [14:0] pCur,
  input wire logic [11:0] xMask,
  input wire logic [2:0] chSel,
  input wire logic [7:0] chBusy,
  input wire logic done,
  input wire logic [14:0] pNext,
  input wire logic [23:0] regA,
  input wire logic [11:0] intMask,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic memAck,
  input wire logic [14:0] memAddr,
  input wire logic [23:0] memWdata,
  input wire logic funcEnable,
  input wire logic [5:0] charOut,
  input wire logic charStrobe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_done_single: assert property (done |=> !done)
    else $error("done longer than a cycle");
  a_skip_offset: assert property (done |-> pNext == pCur + 15'h1 || pNext == pCur + 15'h2)
    else $error("next address off");
  a_func_with_done: assert property (funcEnable |-> done && pNext == pCur + 15'h2)
    else $error("enable without skip");
  a_func_idle_chan: assert property (funcEnable |-> !chBusy[chSel])
    else $error("enable on busy channel");
  a_char_from_a: assert property (charStrobe |-> charOut == regA[5:0] && $stable(regA))
    else $error("character not from A");
  a_req_held: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
    else $error("request dropped");
  a_fill_word: assert property (memReq && memWe && opcode == OPC_LOAD_A |-> memWdata == DESTRUCT_FILL)
    else $error("wrong fill word");
  a_mask_no_gain: assert property ((intMask & ~$past(intMask)) != 12'h0 |-> variant == VAR_SSIM)
    else $error("mask bit set");
  a_mask_clear_sel: assert property (($past(intMask) & ~intMask & ~xMask) == 12'h0)
    else $error("unselected mask bit cleared");
  c_select: cover property (funcEnable);
  c_char: cover property (charStrobe);
  c_fill: cover property (memReq && memWe);
endmodule
bind iss_exec iss_exec_asserts u_iss_exec_asserts (.*);
`default_nettype wire

/* File: bench/iss_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_periph_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [14:0] memAddr,
  input wire logic [23:0] memWdata,
  input wire logic inReady,
  output logic memAck,
  output logic [23:0] memRdata,
  output logic [23:0] inWord,
  output logic inValid
);
  logic [23:0] mem [0:31];
  logic [1:0] waitCnt_q;
  logic [23:0] word_q;
  // released data lines show the inverse of the next word to be offered
  assign inWord = inValid ? word_q : ~word_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memAck <= 1'b0;
      waitCnt_q <= 2'h0;
      memRdata <= 24'h0;
      inValid <= 1'b0;
      word_q <= 24'h5a0001;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memAck) begin
        waitCnt_q <= 2'h0;
      end else if (memReq && waitCnt_q != (slow ? 2'h2 : 2'h0)) begin
        waitCnt_q <= waitCnt_q + 2'h1;
      end else if (memReq) begin
        memAck <= 1'b1;
        memRdata <= mem[memAddr[4:0]];
        if (memWe) mem[memAddr[4:0]] <= memWdata;
      end
      // peripheral offers words, held until taken
      if (inValid && inReady) begin
        inValid <= !slow;
        word_q <= word_q + 24'h1;
      end else begin
        inValid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iss_pkg::*;
  logic clk_sys, rst_b, start, chWide, inValid, memAck, memReq, memWe, done, slow, fe, cs;
  logic relocOperand, destructArmed, funcEnable, charStrobe, inReady;
  logic [5:0] opcode, charOut;
  logic [3:0] variant;
  logic [16:0] operand;
  logic [1:0] bSel;
  logic [2:0] chSel;
  logic [7:0] chBusy;
  logic [11:0] xMask, busyLines, statusLines, intLines, intMask, funcCode, m;
  logic [14:0] pCur, blkCount, pNext, memAddr, y, b1, e;
  logic [23:0] inWord, memRdata, memWdata, regA, regQ, rtcCount, a, q;
  logic [44:0] indexRegs;
  logic [31:0] seed;
  int errCount, numChecks, i, j, waitN;
  iss_exec #(.PAUSE_LIMIT(20), .RTC_LIMIT(5)) u_iss_exec (.*);
  iss_periph_model u_iss_periph_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] shexp(input logic [23:0] v, input logic [14:0] k);
    logic [23:0] kk;
    int n;
    kk = {{9{k[14]}}, k};
    n = kk[5:0] % 24;
    if (kk[23]) return v >> ~kk[5:0];
    return (v << n) | (v >> (24 - n));
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [5:0] op, input logic [3:0] vr, input logic [16:0] opd,
                     input logic [1:0] b, input logic [11:0] x);
    @(negedge clk_sys);
    {opcode, variant, operand, bSel, xMask} = {op, vr, opd, b, x};
    pCur = pCur + 15'h3;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    waitN = 0;
    while (done !== 1'b1 && waitN < 200) begin
      @(negedge clk_sys);
      waitN++;
    end
    chk(done, 1'b1);
    fe = funcEnable;
    cs = charStrobe;
    @(negedge clk_sys);
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    reportAndStop();
  end
  initial begin
    {start, opcode, variant, operand, bSel, xMask, chSel, pCur, blkCount, chBusy} = '0;
    {busyLines, statusLines, intLines, chWide, slow, rst_b} = '0;
    {errCount, numChecks} = '0;
    seed = 32'h3f8f;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      b1 = indexRegs[14:0];
      y = (i == 3) ? b1 : {12'h0, seed[2:0]};
      e = (y == b1) ? 15'h0 : (i[0] ? b1 - 15'h1 : b1 + 15'h1);
      run(OPC_IDX_STEP, i[0] ? VAR_DEC : VAR_PLAIN, {2'h0, y}, 2'h1, 12'h0);
      chk({pNext, indexRegs[14:0]}, {pCur + ((y == b1) ? 15'h2 : 15'h1), e});
      y = i[1] ? e : seed[14:0];
      run(OPC_EQ_SKIP, VAR_PLAIN, {2'h0, y}, 2'h1, 12'h0);
      chk(pNext, pCur + ((y == e) ? 15'h2 : 15'h1));
      run(OPC_GE_SKIP, VAR_PLAIN, {2'h0, y}, 2'h1, 12'h0);
      chk(pNext, pCur + (($signed(e) >= $signed(y)) ? 15'h2 : 15'h1));
    end
    $display("test index done");
    u_iss_periph_model.mem[5] = seed[23:0];
    run(OPC_CHAR_Q, VAR_PLAIN, {15'h5, 2'h0}, 2'h0, 12'h0);
    chk(regQ, {18'h0, seed[23:18]});
    run(OPC_CHAR_A, VAR_PLAIN, {15'h5, 2'h0}, 2'h0, 12'h0);
    chk(regA, {18'h0, seed[23:18]});
    for (j = 0; j < 4; j++) begin
      y = {9'h0, seed[23:18]} + {14'h0, j[0]};
      run(j[1] ? OPC_GE_SKIP : OPC_EQ_SKIP, VAR_Q, {2'h0, y}, 2'h0, 12'h0);
      chk(pNext, pCur + (j[0] ? 15'h1 : 15'h2));
    end
    run(OPC_GE_SKIP, VAR_QS, 17'h7fff, 2'h0, 12'h0);
    chk(pNext, pCur + 15'h2);
    run(OPC_CHAR_OUT, VAR_PLAIN, 17'h0, 2'h0, 12'h0);
    chk({cs, charOut, regA}, {1'b1, seed[23:18], 18'h0, seed[23:18]});
    a = regA;
    q = regQ;
    for (j = 0; j < 3; j++) begin
      y = (j == 2) ? 15'h7ffd : 15'(10 * (j + 1));
      a = shexp(a, y);
      run(OPC_SHIFT, VAR_PLAIN, {2'h0, y}, 2'h0, 12'h0);
      chk(regA, a);
    end
    run(OPC_SHIFT_DBL, VAR_PLAIN, 17'h18, 2'h0, 12'h0);
    chk({regA, regQ}, {q, a});
    for (j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      u_iss_periph_model.mem[20] = seed[23:0];
      u_iss_periph_model.mem[21] = regA | seed[31:8];
      b1 = indexRegs[15 * j +: 15];
      run(OPC_IDX_STEP, VAR_PLAIN, {2'h0, b1}, 2'(j + 1), 12'h0);
      repeat (2) run(OPC_IDX_STEP, VAR_PLAIN, 17'h7000, 2'(j + 1), 12'h0);
      a = regA;
      q = regQ;
      e = 15'h2;
      y = 15'h0;
      while (y == 15'h0) begin
        e = e - 15'h1;
        if (e[14]) y = 15'h1;
        else if (j[0] ? ($signed(a) >= $signed(q & u_iss_periph_model.mem[20 + e]))
                 : (a == (q & u_iss_periph_model.mem[20 + e]))) y = 15'h2;
      end
      run(j[0] ? OPC_MASK_GE : OPC_MASK_EQ, VAR_PLAIN, 17'h14, 2'h1, 12'h0);
      chk({pNext, indexRegs[15 * j +: 15]}, {pCur + y, e});
    end
    a = regA;
    q = regQ;
    i = 0;
    while (a[23] == a[22] && i < 47) begin
      {a, q} = {a[22:0], q, a[23]};
      i++;
    end
    run(OPC_SHIFT_DBL, VAR_SCALE, 17'h30, 2'h3, 12'h0);
    chk({regA, regQ}, {a, q});
    chk(indexRegs[44:30], 15'h30 - 15'(i));
    $display("test char and shift done");
    m = 12'h0;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      run(OPC_MISC, i[0] ? VAR_MASK_SELECTIVE_CLEAR : VAR_SSIM, 17'h0, 2'h0, seed[11:0]);
      m = i[0] ? (m & ~seed[11:0]) : (m | seed[11:0]);
      chk(intMask, m);
      {intLines, statusLines} = seed[27:4];
      run(OPC_MISC, VAR_INTERRUPT_CONDITION_SENSE, 17'h0, 2'h0, 12'h0);
      chk(pNext, pCur + (|(intLines & m) ? 15'h1 : 15'h2));
      run(OPC_MISC, VAR_INS, 17'h0, 2'h0, seed[31:20]);
      chk(pNext, pCur + (|(statusLines & seed[31:20]) ? 15'h1 : 15'h2));
      chBusy = (i == 0) ? 8'hff : seed[7:0];
      chSel = seed[14:12];
      run(OPC_MISC, VAR_SEL, 17'h0, 2'h0, seed[11:0]);
      chk({fe, pNext}, {!chBusy[chSel], pCur + (chBusy[chSel] ? 15'h1 : 15'h2)});
      if (!chBusy[chSel]) chk(funcCode, seed[11:0]);
    end
    busyLines = 12'h010;
    run(OPC_MISC, VAR_BUSY_LINE_PAUSE, 17'h0, 2'h0, 12'h001);
    chk(pNext, pCur + 15'h2);
    run(OPC_MISC, VAR_BUSY_LINE_PAUSE, 17'h0, 2'h0, 12'h030);
    chk({waitN >= 20, pNext}, {1'b1, pCur + 15'h1});
    a = rtcCount;
    run(OPC_MISC, VAR_PRP, 17'h0, 2'h0, 12'h010);
    chk(rtcCount - a <= 24'h1, 1'b1);
    $display("test sense and pause done");
    slow = 1'b1;
    u_iss_periph_model.mem[9] = seed[23:0];
    run(OPC_MISC, VAR_SDL, 17'h0, 2'h0, 12'h0);
    chk(destructArmed, 1'b1);
    run(OPC_LOAD_A, VAR_PLAIN, 17'h9, 2'h0, 12'h0);
    chk({regA, u_iss_periph_model.mem[9]}, {seed[23:0], DESTRUCT_FILL});
    chk(destructArmed, 1'b0);
    for (j = 0; j < 2; j++) begin
      run(OPC_RELOC, j[0] ? VAR_ROS : VAR_RIS, 17'h0, 2'h0, 12'h0);
      chk(relocOperand, j[0]);
    end
    blkCount = 15'h3;
    for (j = 0; j < 2; j++) begin
      chWide = !j[0];
      a = u_iss_periph_model.word_q;
      run(OPC_WORD_IN, VAR_PLAIN, {12'h0, 1'b1, j[0], 3'h0}, 2'h0, 12'h0);
      for (i = 0; i < 3; i++) begin
        q = a + 24'(i);
        chk(u_iss_periph_model.mem[16 + 8 * j + i], chWide ? q : {12'h0, q[11:0]});
      end
    end
    $display("test memory and input done");
    reportAndStop();
  end
endmodule
`default_nettype wire
